// >>> src/sfb_top.v
// Decided for this implementation: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
`default_nettype none
`include "sfb_regs.vh"

module sfb_top #(
	parameter AW         = 8,
	parameter FIFO_DEPTH = 8
) (
	input  wire          clk_sys,
	input  wire          rst_n,
	input  wire [AW-1:0] s_axi_awaddr,
	input  wire          s_axi_awvalid,
	output reg           s_axi_awready,
	input  wire [31:0]   s_axi_wdata,
	input  wire [3:0]    s_axi_wstrb,
	input  wire          s_axi_wvalid,
	output reg           s_axi_wready,
	output reg  [1:0]    s_axi_bresp,
	output reg           s_axi_bvalid,
	input  wire          s_axi_bready,
	input  wire [AW-1:0] s_axi_araddr,
	input  wire          s_axi_arvalid,
	output reg           s_axi_arready,
	output reg  [31:0]   s_axi_rdata,
	output reg  [1:0]    s_axi_rresp,
	output reg           s_axi_rvalid,
	input  wire          s_axi_rready,
	output reg           tx_line_r,
	output reg           sync_serial_clock_r,
	input  wire          rx_line
);

	// configuration registers
	reg        mode_select_r;
	reg        stop_bit_select_r;
	reg [1:0]  char_size_low_bits_r;
	reg        char_size_top_bit_r;
	reg        sync_clock_polarity_r;
	reg        double_speed_r;
	reg [3:0]  baud_divisor_high_r;
	reg [7:0]  baud_divisor_low_r;

	// prescaler
	reg [11:0] presc_r;
	wire       tick;

	// transmit engine
	reg        tx_busy_r;
	reg [12:0] tx_shift_r;
	reg [3:0]  tx_left_r;
	reg [3:0]  tx_sub_r;

	// receive engine
	reg        rx_s1_r;
	reg        rx_s2_r;
	reg        rx_busy_r;
	reg [3:0]  rx_sub_r;
	reg [3:0]  rx_idx_r;
	reg [8:0]  rx_shift_r;
	reg [8:0]  rx_data_r;
	reg        rx_valid_r;

	// bus side
	reg [31:0] rd_nxt;
	reg        rd_err_nxt;
	wire       wr_go;
	wire       rd_go;
	wire       wr_hit_txd;
	wire       wr_lane0;

	// fifo
	wire       fifo_in_ready;
	wire [8:0] fifo_out_data;
	wire       fifo_out_valid;
	wire       fifo_pop;

	wire [11:0] baud_divisor;
	wire [3:0]  char_bits;
	wire [3:0]  sub_end;
	wire [3:0]  rx_half;
	wire        sync_mode;
	wire        bit_start;
	wire        sync_sample;
	wire        rx_sample;
	wire [8:0]  tx_data_fill;
	wire [8:0]  rx_aligned;

	function [3:0] size_decode;
		input [2:0] code;
		begin
			case (code)
				3'b000: size_decode = 4'h5;
				3'b001: size_decode = 4'h6;
				3'b010: size_decode = 4'h7;
				3'b111: size_decode = 4'h9;
				// reserved codes fall back to eight bits
				default: size_decode = 4'h8;
			endcase
		end
	endfunction

	assign baud_divisor = {baud_divisor_high_r, baud_divisor_low_r};
	assign char_bits    = size_decode({char_size_top_bit_r, char_size_low_bits_r});
	assign sync_mode    = mode_select_r;
	assign sub_end      = sync_mode ? `SFB_SUB_END_SYNC :
		(double_speed_r ? `SFB_SUB_END_DBL : `SFB_SUB_END_NORM);
	assign rx_half      = double_speed_r ? `SFB_HALF_DBL : `SFB_HALF_NORM;

	// register bus slave
	assign wr_go      = s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid &&
		!(s_axi_awaddr == `SFB_OFS_TXD && !fifo_in_ready);
	assign rd_go      = s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
	assign wr_lane0   = s_axi_wstrb[0];
	// a full fifo stalls the data write until a slot frees up
	assign wr_hit_txd = wr_go && wr_lane0 && (s_axi_awaddr == `SFB_OFS_TXD);

	always @* begin
		rd_nxt     = 32'h0000_0000;
		rd_err_nxt = 1'b0;
		if (s_axi_araddr == `SFB_OFS_FFC) begin
			rd_nxt[`SFB_FFC_MODE] = mode_select_r;
			rd_nxt[`SFB_FFC_STOP] = stop_bit_select_r;
			rd_nxt[`SFB_FFC_CSZ1:`SFB_FFC_CSZ0] = char_size_low_bits_r;
			rd_nxt[`SFB_FFC_POL] = sync_clock_polarity_r;
		end else if (s_axi_araddr == `SFB_OFS_BDH) begin
			rd_nxt[3:0] = baud_divisor_high_r;
		end else if (s_axi_araddr == `SFB_OFS_BDL) begin
			rd_nxt[7:0] = baud_divisor_low_r;
		end else if (s_axi_araddr == `SFB_OFS_CTLB) begin
			rd_nxt[`SFB_CTLB_CSZ2] = char_size_top_bit_r;
			rd_nxt[`SFB_CTLB_DBL]  = double_speed_r;
		end else if (s_axi_araddr == `SFB_OFS_TXD) begin
			rd_nxt = 32'h0000_0000;
		end else if (s_axi_araddr == `SFB_OFS_RXD) begin
			rd_nxt[8:0]            = rx_data_r;
			rd_nxt[`SFB_RXD_VALID] = rx_valid_r;
		end else if (s_axi_araddr == `SFB_OFS_STAT) begin
			rd_nxt[`SFB_STAT_FULL]   = !fifo_in_ready;
			rd_nxt[`SFB_STAT_TXBUSY] = tx_busy_r;
			rd_nxt[`SFB_STAT_RXVAL]  = rx_valid_r;
		end else begin
			rd_err_nxt = 1'b1;
		end
	end

	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= `SFB_RESP_OKAY;
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rresp   <= `SFB_RESP_OKAY;
			s_axi_rdata   <= 32'h0000_0000;
		end else begin
			s_axi_awready <= wr_go;
			s_axi_wready  <= wr_go;
			if (wr_go) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= (s_axi_awaddr > `SFB_OFS_STAT || s_axi_awaddr[1:0] != 2'b00) ?
					`SFB_RESP_SLVERR : `SFB_RESP_OKAY;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
			s_axi_arready <= rd_go;
			if (rd_go) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata  <= rd_nxt;
				s_axi_rresp  <= rd_err_nxt ? `SFB_RESP_SLVERR : `SFB_RESP_OKAY;
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// configuration writes; reserved bits are never stored
	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			mode_select_r         <= 1'b0;
			stop_bit_select_r     <= 1'b0;
			char_size_low_bits_r  <= 2'b00;
			char_size_top_bit_r   <= 1'b0;
			sync_clock_polarity_r <= 1'b0;
			double_speed_r        <= 1'b0;
			baud_divisor_high_r   <= `SFB_RST_NIB;
			baud_divisor_low_r    <= `SFB_RST_BYTE;
		end else if (wr_go && wr_lane0) begin
			if (s_axi_awaddr == `SFB_OFS_FFC) begin
				mode_select_r         <= s_axi_wdata[`SFB_FFC_MODE];
				stop_bit_select_r     <= s_axi_wdata[`SFB_FFC_STOP];
				char_size_low_bits_r  <= s_axi_wdata[`SFB_FFC_CSZ1:`SFB_FFC_CSZ0];
				sync_clock_polarity_r <= s_axi_wdata[`SFB_FFC_POL];
			end else if (s_axi_awaddr == `SFB_OFS_BDH) begin
				baud_divisor_high_r <= s_axi_wdata[3:0];
			end else if (s_axi_awaddr == `SFB_OFS_BDL) begin
				baud_divisor_low_r <= s_axi_wdata[7:0];
			end else if (s_axi_awaddr == `SFB_OFS_CTLB) begin
				char_size_top_bit_r <= s_axi_wdata[`SFB_CTLB_CSZ2];
				double_speed_r      <= s_axi_wdata[`SFB_CTLB_DBL];
			end
		end
	end

	// baud prescaler
	// one tick every divisor+1 clocks; frames in flight see a low-byte write at once, a high-nibble write only from the next tick
	assign tick = (presc_r == 12'h000);

	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			presc_r <= 12'h000;
		end else if (wr_go && wr_lane0 && s_axi_awaddr == `SFB_OFS_BDL) begin
			presc_r <= {baud_divisor_high_r, s_axi_wdata[7:0]};
		end else if (tick) begin
			presc_r <= baud_divisor;
		end else begin
			presc_r <= presc_r - 1'b1;
		end
	end

	// transmitter
	sfb_fifo #(
		.WIDTH (9),
		.DEPTH (FIFO_DEPTH),
		.AW    (3)
	) u_fifo (
		.clk_sys   (clk_sys),
		.rst_n     (rst_n),
		.in_data   (s_axi_wdata[8:0]),
		.in_valid  (wr_hit_txd),
		.in_ready  (fifo_in_ready),
		.out_data  (fifo_out_data),
		.out_valid (fifo_out_valid),
		.out_ready (fifo_pop)
	);

	assign fifo_pop  = !tx_busy_r && fifo_out_valid;
	assign bit_start = tx_busy_r && tick && (tx_sub_r == 4'h0);
	assign sync_sample = sync_mode && tx_busy_r && tick && (tx_sub_r == `SFB_SYNC_SAMPLE);

	// unused upper data positions become ones and so merge into the stop bits
	genvar gi;
	generate
		for (gi = 0; gi < 9; gi = gi + 1) begin : g_fill
			assign tx_data_fill[gi] = (gi < char_bits) ? fifo_out_data[gi] : 1'b1;
		end
	endgenerate

	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			tx_busy_r           <= 1'b0;
			tx_shift_r          <= 13'h1FFF;
			tx_left_r           <= 4'h0;
			tx_sub_r            <= 4'h0;
			tx_line_r           <= 1'b1;
			sync_serial_clock_r <= 1'b0;
		end else if (!tx_busy_r) begin
			tx_line_r           <= 1'b1;
			sync_serial_clock_r <= sync_clock_polarity_r;
			if (fifo_out_valid) begin
				tx_busy_r  <= 1'b1;
				tx_shift_r <= {3'b111, tx_data_fill, 1'b0};
				tx_left_r  <= 4'h2 + char_bits + {3'b000, stop_bit_select_r};
				tx_sub_r   <= 4'h0;
			end
		end else if (tick) begin
			tx_sub_r <= (tx_sub_r == sub_end) ? 4'h0 : tx_sub_r + 1'b1;
			// launch edge at bit start, sample edge half a bit later
			if (sync_mode) begin
				sync_serial_clock_r <= ~sync_serial_clock_r;
			end
			if (bit_start) begin
				if (tx_left_r == 4'h0) begin
					tx_busy_r           <= 1'b0;
					tx_line_r           <= 1'b1;
					sync_serial_clock_r <= sync_clock_polarity_r;
				end else begin
					tx_line_r  <= tx_shift_r[0];
					tx_shift_r <= {1'b1, tx_shift_r[12:1]};
					tx_left_r  <= tx_left_r - 1'b1;
				end
			end
		end
	end

	// receiver
	// async samples mid-bit; sync samples on the edge opposite the launch edge
	assign rx_sample = sync_mode ? sync_sample :
		(rx_busy_r && tick && rx_sub_r == rx_half);
	assign rx_aligned = rx_shift_r >> (4'h9 - char_bits);

	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			rx_s1_r <= 1'b1;
			rx_s2_r <= 1'b1;
		end else begin
			rx_s1_r <= rx_line;
			rx_s2_r <= rx_s1_r;
		end
	end

	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			rx_busy_r  <= 1'b0;
			rx_sub_r   <= 4'h0;
			rx_idx_r   <= 4'h0;
			rx_shift_r <= 9'h000;
			rx_data_r  <= 9'h000;
			rx_valid_r <= 1'b0;
		end else begin
			if (rd_go && s_axi_araddr == `SFB_OFS_RXD) begin
				rx_valid_r <= 1'b0;
			end
			if (!rx_busy_r) begin
				rx_sub_r <= 4'h0;
				if (sync_mode ? (rx_sample && !rx_s2_r) : !rx_s2_r) begin
					rx_busy_r <= 1'b1;
					rx_idx_r  <= sync_mode ? 4'h1 : 4'h0;
				end
			end else begin
				if (tick) begin
					rx_sub_r <= (rx_sub_r == sub_end) ? 4'h0 : rx_sub_r + 1'b1;
				end
				if (rx_sample) begin
					rx_idx_r <= rx_idx_r + 1'b1;
					if (rx_idx_r == 4'h0 && rx_s2_r) begin
						rx_busy_r <= 1'b0;
					end else if (rx_idx_r != 4'h0 && rx_idx_r <= char_bits) begin
						rx_shift_r <= {rx_s2_r, rx_shift_r[8:1]};
					end else if (rx_idx_r != 4'h0) begin
						// stop bit: a new character wins over a same-cycle read
						rx_busy_r  <= 1'b0;
						rx_data_r  <= rx_aligned;
						rx_valid_r <= 1'b1;
					end
				end
			end
		end
	end

endmodule

`default_nettype wire

// >>> include/sfb_regs.vh
`ifndef SFB_REGS_VH
`define SFB_REGS_VH

// register byte offsets
`define SFB_OFS_FFC      8'h00
`define SFB_OFS_BDH      8'h04
`define SFB_OFS_BDL      8'h08
`define SFB_OFS_CTLB     8'h0C
`define SFB_OFS_TXD      8'h10
`define SFB_OFS_RXD      8'h14
`define SFB_OFS_STAT     8'h18

// frame_format_control fields
`define SFB_FFC_POL      0
`define SFB_FFC_CSZ0     1
`define SFB_FFC_CSZ1     2
`define SFB_FFC_STOP     3
`define SFB_FFC_MODE     6

// control_b_register fields
`define SFB_CTLB_DBL     1
`define SFB_CTLB_CSZ2    2

// receive data register: valid flag above the 9 data bits
`define SFB_RXD_VALID    9

// status register fields
`define SFB_STAT_FULL    0
`define SFB_STAT_TXBUSY  1
`define SFB_STAT_RXVAL   2

// reset values
`define SFB_RST_BYTE     8'h00
`define SFB_RST_NIB      4'h0

// prescaler ticks per bit, minus one, and mid-bit sample point
`define SFB_SUB_END_NORM 4'hF
`define SFB_SUB_END_DBL  4'h7
`define SFB_SUB_END_SYNC 4'h1
`define SFB_HALF_NORM    4'h7
`define SFB_HALF_DBL     4'h3
`define SFB_SYNC_SAMPLE  4'h1

// AXI responses
`define SFB_RESP_OKAY    2'b00
`define SFB_RESP_SLVERR  2'b10

`endif

// >>> src/sfb_fifo.v
`timescale 1ns/10ps
`default_nettype none

module sfb_fifo #(
	parameter WIDTH = 9,
	parameter DEPTH = 8,
	parameter AW    = 3
) (
	input  wire             clk_sys,
	input  wire             rst_n,
	input  wire [WIDTH-1:0] in_data,
	input  wire             in_valid,
	output wire             in_ready,
	output reg  [WIDTH-1:0] out_data,
	output reg              out_valid,
	input  wire             out_ready
);

	reg  [WIDTH-1:0] mem [0:DEPTH-1];
	reg  [AW-1:0]    wr_ptr_r;
	reg  [AW-1:0]    rd_ptr_r;
	reg  [AW:0]      cnt_r;
	wire             push;
	wire             load;

	assign in_ready = (cnt_r != DEPTH[AW:0]);
	assign push     = in_valid && in_ready;
	// output slot refills as soon as it is empty or being taken
	assign load     = (cnt_r != {(AW+1){1'b0}}) && (!out_valid || out_ready);

	always @(posedge clk_sys) begin
		if (push) begin
			mem[wr_ptr_r] <= in_data;
		end
	end

	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			wr_ptr_r  <= {AW{1'b0}};
			rd_ptr_r  <= {AW{1'b0}};
			cnt_r     <= {(AW+1){1'b0}};
			out_data  <= {WIDTH{1'b0}};
			out_valid <= 1'b0;
		end else begin
			if (push) begin
				wr_ptr_r <= (wr_ptr_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr_r + 1'b1;
			end
			if (load) begin
				out_data  <= mem[rd_ptr_r];
				out_valid <= 1'b1;
				rd_ptr_r  <= (rd_ptr_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr_r + 1'b1;
			end else if (out_ready) begin
				out_valid <= 1'b0;
			end
			if (push && !load) begin
				cnt_r <= cnt_r + 1'b1;
			end else if (load && !push) begin
				cnt_r <= cnt_r - 1'b1;
			end
		end
	end

endmodule

`default_nettype wire

// >>> testbench/sfb_top_sva.sv
`timescale 1ns/10ps
`default_nettype none
module sfb_chk #(
	parameter AW = 8
) (
	input wire logic          clk_sys,
	input wire logic          rst_n,
	input wire logic [AW-1:0] s_axi_awaddr,
	input wire logic          s_axi_awvalid,
	input wire logic          s_axi_awready,
	input wire logic          s_axi_wvalid,
	input wire logic          s_axi_wready,
	input wire logic          s_axi_bvalid,
	input wire logic          s_axi_bready,
	input wire logic [AW-1:0] s_axi_araddr,
	input wire logic          s_axi_arvalid,
	input wire logic          s_axi_arready,
	input wire logic [31:0]   s_axi_rdata,
	input wire logic          s_axi_rvalid,
	input wire logic          s_axi_rready
);
	default clocking @(posedge clk_sys);
	endclocking
	default disable iff (!rst_n);
	// transmit data writes may stall on a full buffer
	sequence s_wr_req;
		s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid && s_axi_awaddr != 8'h10;
	endsequence
	sequence s_rd_req;
		s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
	endsequence
	sequence s_rd_done(a);
		$rose(s_axi_rvalid) && s_axi_araddr == a;
	endsequence
	a_wr_accept: assert property (s_wr_req |=> s_axi_awready && s_axi_wready && s_axi_bvalid)
		else $error("write not accepted");
	a_aw_pulse: assert property (s_axi_awready |-> s_axi_wready ##1 !s_axi_awready)
		else $error("write ready not a single pulse");
	a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("write response dropped");
	a_rd_accept: assert property (s_rd_req |=> s_axi_arready && s_axi_rvalid)
		else $error("read not accepted");
	a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data not held");
	a_bdh_rsvd: assert property (s_rd_done(8'h04) |-> s_axi_rdata[31:4] == 28'h0)
		else $error("divisor high reserved bits set");
	a_bdl_width: assert property (s_rd_done(8'h08) |-> s_axi_rdata[31:8] == 24'h0)
		else $error("divisor low wider than a byte");
	a_ffc_rsvd: assert property (s_rd_done(8'h00) |-> s_axi_rdata[31:7] == 25'h0 && s_axi_rdata[5:4] == 2'h0)
		else $error("format register spare bits set");
endmodule
bind sfb_top sfb_chk #(.AW(AW)) u_chk (.clk_sys(clk_sys), .rst_n(rst_n),
	.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
	.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
	.s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
	.s_axi_rready(s_axi_rready));
`default_nettype wire

// >>> testbench/sfb_remote.sv
`timescale 1ns/10ps
`default_nettype none
module sfb_remote (
	input wire logic        clk_sys,
	input wire logic        tx_line,
	input wire logic        en,
	input wire logic [31:0] bit_clks,
	input wire logic [3:0]  nbits,
	output logic            rx_line
);
	logic [8:0] got_q[$];
	int         t_q[$];
	int         cyc = 0;
	logic [8:0] d;
	int         i;
	initial rx_line = 1'b1;
	always @(posedge clk_sys) cyc <= cyc + 1;
	// start edge time kept so the bench can measure frame length
	always begin
		@(posedge clk_sys);
		if (en && !tx_line) begin
			t_q.push_back(cyc);
			repeat (bit_clks / 2) @(posedge clk_sys);
			d = 9'h0;
			for (i = 0; i < nbits; i++) begin
				repeat (bit_clks) @(posedge clk_sys);
				d[i] = tx_line;
			end
			got_q.push_back(d);
			repeat (bit_clks) @(posedge clk_sys);
		end
	end
	task send(input logic [8:0] v);
		int k;
		@(posedge clk_sys);
		rx_line <= 1'b0;
		repeat (bit_clks) @(posedge clk_sys);
		for (k = 0; k < nbits; k++) begin
			rx_line <= v[k];
			repeat (bit_clks) @(posedge clk_sys);
		end
		rx_line <= 1'b1;
		repeat (2 * bit_clks) @(posedge clk_sys);
	endtask
endmodule
`default_nettype wire

// >>> testbench/testbench.sv
`timescale 1ns/10ps
`default_nettype none
`include "sfb_regs.vh"
module testbench;
	logic        clk_sys = 1'b0;
	logic        rst_n = 1'b0;
	logic [7:0]  aw = 8'h00;
	logic [7:0]  ar = 8'h00;
	logic [31:0] wd = 32'h0;
	logic        awv = 1'b0, wv = 1'b0, bry = 1'b0, arv = 1'b0, rry = 1'b0;
	logic        ren = 1'b0, sync_on = 1'b0, pol = 1'b0, tx_p = 1'b1, sc_p = 1'b0, dbl;
	logic [31:0] bit_clks = 32'h10;
	logic [3:0]  nbits = 4'h5;
	logic [31:0] q;
	logic [1:0]  qr;
	logic [8:0]  dt;
	logic [8:0]  exp_q[$];
	logic [2:0]  cz[5] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h7};
	int          mismatches = 0, n_compared = 0, t0, i, j, k;
	wire         awr, wrd, bv, arr, rv, tx, sclk, rxl;
	wire  [1:0]  br, rr;
	wire  [31:0] rdd;
	always #10 clk_sys = ~clk_sys;
	sfb_top DUT (.clk_sys(clk_sys), .rst_n(rst_n), .s_axi_awaddr(aw), .s_axi_awvalid(awv),
		.s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv),
		.s_axi_wready(wrd), .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bry),
		.s_axi_araddr(ar), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdd),
		.s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rry), .tx_line_r(tx),
		.sync_serial_clock_r(sclk), .rx_line(rxl));
	sfb_remote u_rem (.clk_sys(clk_sys), .tx_line(tx), .en(ren), .bit_clks(bit_clks),
		.nbits(nbits), .rx_line(rxl));
	function int bclk(input logic b, input int dv);
		return (b ? 8 : 16) * (dv + 1);
	endfunction
	function logic [3:0] nb(input logic [2:0] c);
		return c == 3'h7 ? 4'h9 : 4'h5 + c;
	endfunction
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			mismatches++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		aw <= a;
		wd <= d;
		awv <= 1'b1;
		wv <= 1'b1;
		do @(posedge clk_sys); while (bv !== 1'b1);
		// late bready makes the slave hold its response a cycle
		awv <= 1'b0;
		wv <= 1'b0;
		bry <= 1'b1;
		@(posedge clk_sys);
		bry <= 1'b0;
		qr = br;
	endtask
	task rd(input logic [7:0] a);
		@(posedge clk_sys);
		ar <= a;
		arv <= 1'b1;
		do @(posedge clk_sys); while (rv !== 1'b1);
		// late rready makes the slave hold its read data a cycle
		arv <= 1'b0;
		rry <= 1'b1;
		@(posedge clk_sys);
		rry <= 1'b0;
		q = rdd;
		qr = rr;
	endtask
	task drain(input int gap);
		int d, n;
		while (u_rem.got_q.size() < exp_q.size()) @(posedge clk_sys);
		for (n = 0; exp_q.size() > 0; n++) begin
			chk("tx char", exp_q.pop_front(), u_rem.got_q.pop_front());
			d = u_rem.t_q.pop_front();
			n_compared++;
			if (n > 0 && (d - t0 < gap || d - t0 > gap + 4)) begin
				mismatches++;
				$display("[ERR] frame spacing expected %0d seen %0d", gap, d - t0);
			end
			t0 = d;
		end
	endtask
	task cfg(input int dv, input logic b, input logic [2:0] c, input logic st, input logic m);
		do rd(`SFB_OFS_STAT); while (q[`SFB_STAT_TXBUSY] !== 1'b0);
		wr(`SFB_OFS_BDH, 32'h0);
		wr(`SFB_OFS_BDL, dv);
		wr(`SFB_OFS_CTLB, {29'h0, c[2], b, 1'b0});
		wr(`SFB_OFS_FFC, {25'h0, m, 2'h0, st, c[1:0], pol});
		bit_clks <= bclk(b, dv);
		nbits <= nb(c);
	endtask
	task end_sim;
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// launch must coincide with the leading clock edge
	always @(posedge clk_sys) begin
		if (sync_on && tx !== tx_p && !(sclk !== sc_p && sclk === ~pol)) begin
			mismatches++;
			$display("[ERR] sync launch edge expected %b seen %b", ~pol, sclk);
		end
		tx_p <= tx;
		sc_p <= sclk;
	end
	initial begin
		#(20 * 90000);
		mismatches++;
		end_sim;
	end
	initial begin
		void'($urandom(53528));
		repeat (3) @(posedge clk_sys);
		rst_n <= 1'b1;
		for (i = 0; i < 16; i += 4) begin
			rd(i);
			chk("reset value", 32'h0, q);
		end
		for (i = 0; i < 4; i++) begin
			j = $urandom;
			wr(`SFB_OFS_BDH, j[3:0]);
			wr(`SFB_OFS_BDL, j[15:8]);
			rd(`SFB_OFS_BDH);
			chk("divisor high", {28'h0, j[3:0]}, q);
			rd(`SFB_OFS_BDL);
			chk("divisor low", {24'h0, j[15:8]}, q);
		end
		wr(8'h20, 32'h1);
		chk("unmapped write resp", `SFB_RESP_SLVERR, qr);
		rd(8'h1C);
		chk("unmapped read resp", `SFB_RESP_SLVERR, qr);
		$display("test registers done");
		ren <= 1'b1;
		for (i = 0; i < 10; i++) begin
			j = $urandom_range(2);
			dbl = $urandom_range(1);
			cfg(j, dbl, cz[i / 2], i % 2, 1'b0);
			for (k = 0; k < 2; k++) begin
				dt = $urandom & ((1 << nb(cz[i / 2])) - 1);
				exp_q.push_back(dt);
				wr(`SFB_OFS_TXD, dt);
			end
			drain((2 + nb(cz[i / 2]) + i % 2) * bclk(dbl, j));
		end
		$display("test frame formats done");
		cfg(2, 1'b0, 3'h3, 1'b0, 1'b0);
		for (k = 0; k < 10; k++) begin
			dt = $urandom & 9'hFF;
			exp_q.push_back(dt);
			wr(`SFB_OFS_TXD, dt);
		end
		rd(`SFB_OFS_STAT);
		chk("buffer full", 1, q[`SFB_STAT_FULL]);
		drain(10 * 48);
		rd(`SFB_OFS_STAT);
		chk("buffer full", 0, q[`SFB_STAT_FULL]);
		chk("async clock idle", 0, sclk);
		$display("test buffer done");
		for (k = 0; k < 2; k++) begin
			dt = $urandom & 9'hFF;
			u_rem.send(dt);
			rd(`SFB_OFS_RXD);
			chk("rx char", {22'h0, 1'b1, dt}, q);
			rd(`SFB_OFS_RXD);
			chk("rx flag", 0, q[`SFB_RXD_VALID]);
		end
		$display("test receive done");
		ren <= 1'b0;
		for (k = 0; k < 2; k++) begin
			pol <= k[0];
			cfg(1, 1'b0, 3'h3, 1'b0, 1'b1);
			sync_on <= 1'b1;
			wr(`SFB_OFS_TXD, 32'hA5);
			wait (tx === 1'b0);
			do rd(`SFB_OFS_STAT); while (q[`SFB_STAT_TXBUSY] !== 1'b0);
			chk("sync clock idle", pol, sclk);
			sync_on <= 1'b0;
		end
		$display("test sync done");
		end_sim;
	end
endmodule
`default_nettype wire
